// file: rtl/prioritized_vector_interrupt_ctrl.v
// prioritized vector interrupt controller: 29 sources, 10 vectors, 3 levels
// How it works
// - twenty-nine sources are merged onto ten vector addresses
// - three levels: top beats high, high beats low
// - requests at or below the level in service are refused
// - simultaneous vectors: highest level is granted
// - equal level: smallest vector address is granted
// - pins zero and one use 00003H and 0000BH, top or low
// - 00013H serves pins two, four and timer zero low; high or low only
// - 0001BH, 00023H and 0002BH serve their listed sources
// - 00033H and 0003BH serve serial receive and transmit groups
// - 00043H and 0004BH serve converter, timers, pulse-width, port zero
// - halt ends on system reset or any interrupt
// - hold ends on reset pin low, pins 0,1,2,4,5, or port zero
// - crystal hold also ends on a base timer interrupt
// - pin zero detects rise, fall, high or low, never both edges
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module prioritized_vector_interrupt_ctrl (
	input wire clk,
	input wire rstn,
	// source order: 0 pin0, 1 pin1, 2 pin2, 3 timer0 low, 4 pin4,
	// 5 pin3, 6 pin5, 7 base timer0, 8 base timer1, 9 timer0 high, 10 pin6,
	// 11 timer1 low, 12 timer1 high, 13 pin7, 14 serial0, 15 uart1 rx,
	// 16 uart2 rx, 17 serial1, 18 uart1 tx, 19 uart2 tx, 20 converter,
	// 21 timer6, 22 timer7, 23 pwm4, 24 pwm5, 25 port0, 26 timer4,
	// 27 timer5, 28 pwm2/pwm3
	input wire [28:0] src_event,
	input wire [28:0] src_enable,
	input wire [28:0] src_clear,
	input wire ext_irq_pin_zero,
	input wire [1:0] ext0_mode,
	input wire ext_irq_pin_one,
	input wire ext_irq_pin_two,
	input wire ext_irq_pin_four,
	input wire ext_irq_pin_five,
	input wire [4:0] wake_pin_level,
	input wire port0_irq,
	input wire [9:0] vec_high_sel,
	input wire ack,
	input wire ret,
	input wire halt_enter,
	input wire hold_enter,
	input wire xtal_hold_enter,
	input wire reset_pin_n,
	output wire irq_req,
	output reg [19:0] irq_vector,
	output reg [1:0] irq_level,
	output reg [1:0] active_level,
	output wire halted,
	output wire held,
	output wire xtal_held,
	output wire wake
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// vector index to first/last source index
	function [4:0] vec_lo;
		input [3:0] v;
		begin
			case (v)
				4'h0: vec_lo = `V0_LO;
				4'h1: vec_lo = `V1_LO;
				4'h2: vec_lo = `V2_LO;
				4'h3: vec_lo = `V3_LO;
				4'h4: vec_lo = `V4_LO;
				4'h5: vec_lo = `V5_LO;
				4'h6: vec_lo = `V6_LO;
				4'h7: vec_lo = `V7_LO;
				4'h8: vec_lo = `V8_LO;
				default: vec_lo = `V9_LO;
			endcase
		end
	endfunction
	function [4:0] vec_hi;
		input [3:0] v;
		begin
			case (v)
				4'h0: vec_hi = `V0_HI;
				4'h1: vec_hi = `V1_HI;
				4'h2: vec_hi = `V2_HI;
				4'h3: vec_hi = `V3_HI;
				4'h4: vec_hi = `V4_HI;
				4'h5: vec_hi = `V5_HI;
				4'h6: vec_hi = `V6_HI;
				4'h7: vec_hi = `V7_HI;
				4'h8: vec_hi = `V8_HI;
				default: vec_hi = `V9_HI;
			endcase
		end
	endfunction
	// ------------------------------------------------------------
	// source capture
	// ------------------------------------------------------------
	wire ext0_hit;
	ext0_detect u_ext0 (
		.clk(clk),
		.rstn(rstn),
		.pin(ext_irq_pin_zero),
		.mode(ext0_mode),
		.hit(ext0_hit)
	);
	wire [28:0] set_vec;
	assign set_vec = {src_event[28:1], src_event[0] | ext0_hit};
	reg [28:0] pend_reg;
	wire [28:0] pend_next;
	// pending flags
	// set wins over clear so an event in the clear cycle is kept
	assign pend_next = set_vec | (pend_reg & ~src_clear);
	always @(posedge clk) begin
		if (!rstn) begin
			pend_reg <= 29'h0;
		end else begin
			pend_reg <= pend_next;
		end
	end
	wire [28:0] live;
	assign live = pend_reg & src_enable;
	// ------------------------------------------------------------
	// vector request and level
	// ------------------------------------------------------------
	wire [9:0] vreq;
	wire [19:0] vlvl;
	genvar gv;
	generate
		for (gv = 0; gv < `NUM_VEC; gv = gv + 1) begin : g_vec
			wire [28:0] win;
			assign win = ({29{1'b1}} >> (5'd28 - vec_hi(gv))) &
				({29{1'b1}} << vec_lo(gv));
			assign vreq[gv] = |(live & win);
			// level choice per vector
			// first two vectors: top or low; the rest: high or low
			assign vlvl[gv*2 +: 2] = (gv < 2) ?
				(vec_high_sel[gv] ? `LVL_TOP : `LVL_LOW) :
				(vec_high_sel[gv] ? `LVL_HIGH : `LVL_LOW);
		end
	endgenerate
	// ------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------
	reg [3:0] win_idx;
	reg [1:0] win_lvl;
	integer i;
	always @* begin
		win_idx = 4'h0;
		win_lvl = `LVL_NONE;
		// highest level, then lowest address
		// scanning downward with >= lets the smaller index win ties
		for (i = `NUM_VEC - 1; i >= 0; i = i - 1) begin
			if (vreq[i] && vlvl[i*2 +: 2] >= win_lvl) begin
				win_idx = i[3:0];
				win_lvl = vlvl[i*2 +: 2];
			end
		end
	end
	assign irq_req = (win_lvl != `LVL_NONE) && (win_lvl > active_level);
	// level stack: one bit per level in service
	reg [2:0] svc_reg;
	reg [2:0] svc_next;
	always @* begin
		svc_next = svc_reg;
		if (ret) begin
			if (svc_reg[2]) begin
				svc_next[2] = 1'b0;
			end else if (svc_reg[1]) begin
				svc_next[1] = 1'b0;
			end else begin
				svc_next[0] = 1'b0;
			end
		end
		if (ack && irq_req) begin
			svc_next[win_lvl - 2'h1] = 1'b1;
		end
	end
	always @(posedge clk) begin
		if (!rstn) begin
			svc_reg <= 3'h0;
			active_level <= `LVL_NONE;
			irq_vector <= 20'h0;
			irq_level <= `LVL_NONE;
		end else begin
			svc_reg <= svc_next;
			active_level <= svc_next[2] ? `LVL_TOP : svc_next[1] ? `LVL_HIGH :
				svc_next[0] ? `LVL_LOW : `LVL_NONE;
			irq_vector <= `VEC_BASE + `VEC_STEP * {16'h0, win_idx};
			irq_level <= win_lvl;
		end
	end
	// ------------------------------------------------------------
	// standby
	// ------------------------------------------------------------
	reg halt_reg;
	reg hold_reg;
	reg xhold_reg;
	wire hold_wake;
	assign hold_wake = ~reset_pin_n |
		(ext_irq_pin_zero == wake_pin_level[0]) |
		(ext_irq_pin_one == wake_pin_level[1]) |
		(ext_irq_pin_two == wake_pin_level[2]) |
		(ext_irq_pin_four == wake_pin_level[3]) |
		(ext_irq_pin_five == wake_pin_level[4]) |
		port0_irq | pend_reg[`SRC_PORT0];
	// base timer also releases crystal hold
	wire xhold_wake;
	assign xhold_wake = hold_wake | pend_reg[`SRC_BT0] | pend_reg[`SRC_BT1];
	wire halt_wake;
	assign halt_wake = |live;
	always @(posedge clk) begin
		if (!rstn) begin
			halt_reg <= 1'b0;
			hold_reg <= 1'b0;
			xhold_reg <= 1'b0;
		end else begin
			halt_reg <= halt_wake ? 1'b0 : (halt_reg | halt_enter);
			hold_reg <= hold_wake ? 1'b0 : (hold_reg | hold_enter);
			xhold_reg <= xhold_wake ? 1'b0 : (xhold_reg | xtal_hold_enter);
		end
	end
	assign halted = halt_reg;
	assign held = hold_reg;
	assign xtal_held = xhold_reg;
	assign wake = (halt_reg & halt_wake) | (hold_reg & hold_wake) |
		(xhold_reg & xhold_wake);
endmodule // prioritized_vector_interrupt_ctrl
`default_nettype wire

// file: common/irq_ctrl_defines.vh
// constants for the prioritized vector interrupt controller
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH
`define NUM_SRC 29
`define NUM_VEC 10
`define VEC_W 4
// priority level codes, larger wins
`define LVL_NONE 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_TOP 2'h3
// vector addresses
`define VEC_BASE 20'h00003
`define VEC_STEP 20'h00008
// external pin zero detection modes
`define DET_RISE 2'h0
`define DET_FALL 2'h1
`define DET_HIGH 2'h2
`define DET_LOW 2'h3
// source index ranges of each vector
`define V0_LO 0
`define V0_HI 0
`define V1_LO 1
`define V1_HI 1
`define V2_LO 2
`define V2_HI 4
`define V3_LO 5
`define V3_HI 8
`define V4_LO 9
`define V4_HI 10
`define V5_LO 11
`define V5_HI 13
`define V6_LO 14
`define V6_HI 16
`define V7_LO 17
`define V7_HI 19
`define V8_LO 20
`define V8_HI 24
`define V9_LO 25
`define V9_HI 28
// source indices needed by wake logic
`define SRC_EXT2 2
`define SRC_EXT4 4
`define SRC_EXT5 6
`define SRC_BT0 7
`define SRC_BT1 8
`define SRC_PORT0 25
`endif

// file: rtl/ext0_detect.v
// edge/level detector for external pin zero
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module ext0_detect (
	input wire clk,
	input wire rstn,
	input wire pin,
	input wire [1:0] mode,
	output wire hit
);
	reg prev_reg;
	always @(posedge clk) begin
		if (!rstn) begin
			// track the pin in reset so a pin idling high gives no false rise
			prev_reg <= pin;
		end else begin
			prev_reg <= pin;
		end
	end
	// four modes only
	// no both-edges mode exists; the mode field has exactly four codes
	assign hit = (mode == `DET_RISE) ? (pin & ~prev_reg) :
		(mode == `DET_FALL) ? (~pin & prev_reg) :
		(mode == `DET_HIGH) ? pin : ~pin;
endmodule // ext0_detect
`default_nettype wire

// file: testbench/irq_ctrl_props.sv
// assertions on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props (
	input wire clk,
	input wire rstn,
	input wire ack,
	input wire ret,
	input wire reset_pin_n,
	input wire irq_req,
	input wire [19:0] irq_vector,
	input wire [1:0] irq_level,
	input wire [1:0] active_level,
	input wire held,
	input wire xtal_held,
	input wire wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_addr; irq_level != 2'h0 |-> irq_vector[2:0] == 3'h3 && irq_vector <= 20'h0004B; endproperty
	a_addr: assert property (p_addr) else $error("bad vector");
	property p_ext; irq_level != 2'h0 && irq_vector < 20'h00013 |-> irq_level != 2'h2; endproperty
	a_ext: assert property (p_ext) else $error("bad pin level");
	property p_rest; irq_vector >= 20'h00013 |-> irq_level != 2'h3; endproperty
	a_rest: assert property (p_rest) else $error("bad vector level");
	property p_top; active_level == 2'h3 |-> !irq_req; endproperty
	a_top: assert property (p_top) else $error("request over top");
	property p_nest; ack && irq_req && !ret |=> active_level > $past(active_level); endproperty
	a_nest: assert property (p_nest) else $error("no nesting");
	property p_pop; ret && !ack && active_level != 2'h0 |=> active_level < $past(active_level); endproperty
	a_pop: assert property (p_pop) else $error("no pop");
	property p_hold; held && !reset_pin_n |-> wake; endproperty
	a_hold: assert property (p_hold) else $error("hold kept");
	property p_xtal; xtal_held && !reset_pin_n |-> wake; endproperty
	a_xtal: assert property (p_xtal) else $error("crystal hold kept");
endmodule // irq_ctrl_props
bind prioritized_vector_interrupt_ctrl irq_ctrl_props i_irq_ctrl_props (.clk(clk), .rstn(rstn),
	.ack(ack), .ret(ret), .reset_pin_n(reset_pin_n), .irq_req(irq_req), .irq_vector(irq_vector),
	.irq_level(irq_level), .active_level(active_level), .held(held), .xtal_held(xtal_held),
	.wake(wake));
`default_nettype wire

// file: testbench/cpu_core_model.sv
// cpu core model that takes interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input wire clk,
	input wire rstn,
	input wire take,
	input wire irq_req,
	input wire [1:0] irq_level,
	input wire [19:0] irq_vector,
	output reg ack,
	output reg [19:0] got_vec
);
	always @(posedge clk) begin
		if (!rstn) begin
			ack <= 1'b0;
			got_vec <= 20'h00000;
		end else begin
			if (ack)
				got_vec <= irq_vector;
			ack <= take && irq_req && !ack && irq_level != 2'h0;
		end
	end
endmodule // cpu_core_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module tb;
	reg clk = 1'b0;
	reg rstn, p0, ret, he, ho, xh, rpn, take;
	reg [28:0] ev, en, clr, m, e;
	reg [1:0] md;
	reg [4:0] wl, pw;
	reg [9:0] hs, h;
	reg [21:0] w;
	wire req, ack, halted, held, xheld, wake;
	wire [19:0] vec, got;
	wire [1:0] lvl, act;
	integer seed, i, fail_count, cmp_count, cyc_cnt;
	always #50 clk = ~clk;
	prioritized_vector_interrupt_ctrl i_prioritized_vector_interrupt_ctrl (.clk(clk), .rstn(rstn),
		.src_event(ev), .src_enable(en), .src_clear(clr), .ext_irq_pin_zero(p0), .ext0_mode(md),
		.ext_irq_pin_one(pw[0]), .ext_irq_pin_two(pw[1]), .ext_irq_pin_four(pw[2]),
		.ext_irq_pin_five(pw[3]), .wake_pin_level(wl), .port0_irq(pw[4]), .vec_high_sel(hs),
		.ack(ack), .ret(ret), .halt_enter(he), .hold_enter(ho), .xtal_hold_enter(xh),
		.reset_pin_n(rpn), .irq_req(req), .irq_vector(vec), .irq_level(lvl),
		.active_level(act), .halted(halted), .held(held), .xtal_held(xheld), .wake(wake));
	cpu_core_model i_cpu_core_model (.clk(clk), .rstn(rstn), .take(take), .irq_req(req),
		.irq_level(lvl), .irq_vector(vec), .ack(ack), .got_vec(got));
	// ----------
	// helpers
	// ----------
	function integer vof(input integer s);
		vof = (s >= `V1_LO) + (s >= `V2_LO) + (s >= `V3_LO) + (s >= `V4_LO) + (s >= `V5_LO)
			+ (s >= `V6_LO) + (s >= `V7_LO) + (s >= `V8_LO) + (s >= `V9_LO);
	endfunction
	// descending scan so a smaller vector wins a level tie
	function [21:0] win(input [28:0] mk, input [9:0] hv);
		integer s, v;
		reg [1:0] l;
		begin
			win = 22'h0;
			for (s = 28; s >= 0; s = s - 1) begin
				v = vof(s);
				l = !hv[v] ? `LVL_LOW : v < 2 ? `LVL_TOP : `LVL_HIGH;
				if (mk[s] && l >= win[21:20]) begin
					win[21:20] = l;
					win[19:0] = `VEC_BASE + `VEC_STEP * v;
				end
			end
		end
	endfunction
	task chk(input [63:0] seen, input [63:0] exp, input [8*6:1] what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task test_done;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			fail_count = fail_count + 1;
			test_done;
		end
	end
	initial begin
		seed = 22; fail_count = 0; cmp_count = 0; cyc_cnt = 0;
		rstn = 0; ev = 0; en = 0; clr = 0; p0 = 0; md = 0; wl = 5'h1F; hs = 0;
		ret = 0; he = 0; ho = 0; xh = 0; rpn = 1; take = 0; pw = 0;
		tick(2); rstn <= 1'b1;
		for (i = 0; i < 60; i = i + 1) begin
			m = i == 0 ? 29'h1FFFFFFF : $random(seed) & $random(seed);
			e = i == 0 ? 29'h1FFFFFFF : $random(seed);
			h = $random(seed);
			w = win(m & e, h);
			ev <= m; en <= e; hs <= h;
			tick(1); ev <= 29'h0; tick(2); @(negedge clk);
			chk(lvl, w[21:20], "level");
			if (w[21:20] != 2'h0) chk(vec, w[19:0], "vector");
			chk(req, (m & e) != 0, "req");
			tick(1); clr <= {29{1'b1}}; tick(1); clr <= 29'h0;
		end
		en <= {29{1'b1}}; hs <= 10'h005; take <= 1'b1; ev <= 29'h20;
		tick(1); ev <= 29'h0; tick(6); @(negedge clk);
		chk(act, `LVL_LOW, "active");
		chk(got, 20'h0001B, "taken");
		tick(1); ev <= 29'h200; tick(1); ev <= 29'h0; tick(4); @(negedge clk);
		chk(req, 1'b0, "req");
		tick(1); ev <= 29'h4; tick(1); ev <= 29'h0; tick(6); @(negedge clk);
		chk(act, `LVL_HIGH, "active");
		chk(got, 20'h00013, "taken");
		// pin zero vector at top level nests over the high level in service
		tick(1); ev <= 29'h1; tick(1); ev <= 29'h0; tick(6); @(negedge clk);
		chk(act, `LVL_TOP, "active");
		chk(got, `VEC_BASE, "taken");
		chk(req, 1'b0, "req");
		tick(1); take <= 1'b0; clr <= {29{1'b1}}; ret <= 1'b1;
		tick(3); ret <= 1'b0; clr <= 29'h0; tick(1); @(negedge clk);
		chk(act, 2'h0, "active");
		// pin zero: start idle, then move to the active side
		for (i = 0; i < 4; i = i + 1) begin
			tick(1); en <= 29'h1; hs <= 10'h0; md <= i; p0 <= i[0];
			tick(3); clr <= 29'h1; tick(1); clr <= 29'h0; tick(2); @(negedge clk);
			chk(req, 1'b0, "pin0");
			tick(1); p0 <= ~i[0]; tick(3); @(negedge clk);
			chk(vec, `VEC_BASE, "pin0");
			chk(req, 1'b1, "pin0");
			chk(lvl, `LVL_LOW, "pin0");
		end
		tick(1); clr <= {29{1'b1}}; en <= 29'h0; he <= 1'b1;
		tick(1); clr <= 29'h0; he <= 1'b0; tick(1); @(negedge clk);
		chk(halted, 1'b1, "halt");
		tick(1); en <= 29'h20; ev <= 29'h20; tick(1); ev <= 29'h0; tick(3); @(negedge clk);
		chk(halted, 1'b0, "halt");
		tick(1); clr <= {29{1'b1}}; en <= 29'h0; ho <= 1'b1;
		tick(1); clr <= 29'h0; ho <= 1'b0; tick(2); @(negedge clk);
		chk(wake, 1'b0, "wake");
		tick(1); rpn <= 1'b0; @(negedge clk);
		chk(held, 1'b1, "held");
		chk(wake, 1'b1, "wake");
		tick(1); rpn <= 1'b1;
		// pins one, two, four and five, then the port zero condition, each end hold
		for (i = 0; i < 5; i = i + 1) begin
			tick(1); ho <= 1'b1; tick(1); ho <= 1'b0; tick(1); pw <= 5'h01 << i; @(negedge clk);
			chk(held, 1'b1, "held");
			chk(wake, 1'b1, "wake");
			tick(1); pw <= 5'h00;
		end
		tick(2); xh <= 1'b1; tick(1); xh <= 1'b0; tick(2); @(negedge clk);
		chk(xheld, 1'b1, "xtal");
		tick(1); en <= 29'h80; ev <= 29'h80; tick(1); ev <= 29'h0; @(negedge clk);
		chk(wake, 1'b1, "wake");
		// crystal hold again, this time released by the reset pin
		tick(1); clr <= {29{1'b1}}; en <= 29'h0;
		tick(1); clr <= 29'h0; xh <= 1'b1;
		tick(1); xh <= 1'b0;
		tick(1); rpn <= 1'b0; @(negedge clk);
		chk(xheld, 1'b1, "xtal");
		chk(wake, 1'b1, "wake");
		tick(1); rpn <= 1'b1;
		tick(2);
		test_done;
	end
endmodule // tb
`default_nettype wire
